// ===== hdl/i2c_bus_defs.svh
`ifndef I2C_BUS_DEFS_SVH
`define I2C_BUS_DEFS_SVH

// Register offsets
`define REG_TARGET 5'h00
`define REG_MCTRL 5'h04
`define REG_MDATA 5'h08
`define REG_DIV 5'h0C
`define REG_SADDR 5'h10
`define REG_SSTAT 5'h14
`define REG_SDATA 5'h18
`define REG_CONFIG 5'h1C

// Master command bits (write of master control)
`define CMD_RUN 0
`define CMD_START 1
`define CMD_STOP 2
`define CMD_ACK 3

// Master status bits (read of master control)
`define ST_BUSY 0
`define ST_ERROR 1
`define ST_ADRNACK 2
`define ST_DATNACK 3
`define ST_ARBLOST 4
`define ST_IDLE 5
`define ST_BUSBUSY 6

// Slave status and configuration bits
`define SS_RXREQ 0
`define SS_TXREQ 1
`define SS_FIRST 2
`define CFG_MEN 0
`define CFG_SEN 1

// Reset values
`define DIV_RESET 8'h01
`define CFG_RESET 2'h0

// Clock phase units
`define LOW_UNITS 4'h6
`define PERIOD_LAST 4'h9
`define DATA_SET_UNIT 4'h3
`define SAMPLE_UNIT 4'h8
`define START_FALL_UNIT 4'h5
`define STOP_RELEASE_UNIT 4'h8
`define ACK_BIT 4'h8

`endif

// ===== hdl/i2c_bus_engine.sv
`include "i2c_bus_defs.svh"

module i2c_bus_engine #(
	parameter int DIV_WIDTH = 8
) (
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire logic [4:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic serial_data_pin_in,
	output logic serial_data_pin_out,
	output logic serial_data_pin_oe_n,
	input wire logic serial_clock_pin_in,
	output logic serial_clock_pin_out,
	output logic serial_clock_pin_oe_n
);

	if (DIV_WIDTH < 1 || DIV_WIDTH > 16)
	begin : g_bad_width
		$error("DIV_WIDTH must lie in 1..16");
	end

	////////////////////////////////////////////////////////////////////////
	// Synchronizers and bus conditions

	logic sda_meta, sda_s, sda_d;
	logic scl_meta, scl_s, scl_d;

	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			sda_meta <= 1'b1;
			sda_s <= 1'b1;
			sda_d <= 1'b1;
			scl_meta <= 1'b1;
			scl_s <= 1'b1;
			scl_d <= 1'b1;
		end
		else
		begin
			sda_meta <= serial_data_pin_in;
			sda_s <= sda_meta;
			sda_d <= sda_s;
			scl_meta <= serial_clock_pin_in;
			scl_s <= scl_meta;
			scl_d <= scl_s;
		end
	end

	wire scl_rise = scl_s & ~scl_d;
	wire scl_fall = ~scl_s & scl_d;
	wire start_det = scl_s & scl_d & sda_d & ~sda_s;
	wire stop_det = scl_s & scl_d & ~sda_d & sda_s;

	logic bus_busy;
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
			bus_busy <= 1'b0;
		else if (start_det)
			bus_busy <= 1'b1;
		else if (stop_det)
			bus_busy <= 1'b0;
	end

	wire bus_idle = ~bus_busy & scl_s & sda_s;

	////////////////////////////////////////////////////////////////////////
	// Registers

	logic [7:0] master_target_address_reg;
	logic [DIV_WIDTH-1:0] clock_divider_value;
	logic [1:0] cfg;
	logic [6:0] own_addr;
	logic [7:0] m_tx_data, m_rx_data, s_tx_data, s_rx_data;
	logic cmd_stop, cmd_ack;
	logic err_adr, err_dat, err_arb;
	logic rx_req, tx_req, first_byte;
	logic [31:0] rd_mux;

	wire wr_target = reg_wr && reg_addr == `REG_TARGET;
	wire wr_mctrl = reg_wr && reg_addr == `REG_MCTRL;
	wire wr_mdata = reg_wr && reg_addr == `REG_MDATA;
	wire wr_div = reg_wr && reg_addr == `REG_DIV;
	wire wr_saddr = reg_wr && reg_addr == `REG_SADDR;
	wire wr_sdata = reg_wr && reg_addr == `REG_SDATA;
	wire wr_config = reg_wr && reg_addr == `REG_CONFIG;
	wire rd_sdata = reg_rd && reg_addr == `REG_SDATA;
	wire cmd_run = reg_wdata[`CMD_RUN];
	wire cmd_start = reg_wdata[`CMD_START];
	wire master_en = cfg[`CFG_MEN];
	wire slave_en = cfg[`CFG_SEN];

	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			master_target_address_reg <= 8'h00;
			clock_divider_value <= DIV_WIDTH'(`DIV_RESET);
			cfg <= `CFG_RESET;
			own_addr <= 7'h00;
			m_tx_data <= 8'h00;
			s_tx_data <= 8'h00;
			cmd_stop <= 1'b0;
			cmd_ack <= 1'b0;
		end
		else
		begin
			if (wr_target)
				master_target_address_reg <= reg_wdata[7:0];
			if (wr_div)
				clock_divider_value <= reg_wdata[DIV_WIDTH-1:0];
			if (wr_config)
				cfg <= reg_wdata[1:0];
			if (wr_saddr)
				own_addr <= reg_wdata[6:0];
			if (wr_mdata)
				m_tx_data <= reg_wdata[7:0];
			if (wr_sdata)
				s_tx_data <= reg_wdata[7:0];
			if (wr_mctrl)
			begin
				cmd_stop <= reg_wdata[`CMD_STOP];
				cmd_ack <= reg_wdata[`CMD_ACK];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Master: phase timer

	i2c_bus_pkg::master_state_t m_state;
	logic [DIV_WIDTH:0] pre;
	logic [3:0] ph, m_bits;
	logic [7:0] m_shift;
	logic m_sda_low, addr_phase, ack_seen;

	wire m_dir = master_target_address_reg[0];
	wire m_run = m_state != i2c_bus_pkg::M_IDLE &&
		m_state != i2c_bus_pkg::M_WAIT;
	wire m_scl_low = m_state == i2c_bus_pkg::M_WAIT ||
		((m_state == i2c_bus_pkg::M_BIT || m_state == i2c_bus_pkg::M_RSTART
		|| m_state == i2c_bus_pkg::M_STOP) && ph < `LOW_UNITS);
	wire [DIV_WIDTH:0] unit_last = {clock_divider_value, 1'b1};
	// hold timer at unit end while clock held low
	wire stretch = m_run && ph >= `LOW_UNITS && ~m_scl_low && ~scl_s &&
		pre == unit_last;
	wire tick = m_run && ~stretch && pre == unit_last;
	wire ph_last = ph == `PERIOD_LAST;
	wire m_sending = addr_phase || ~m_dir;
	wire at_sample = tick && ph == `SAMPLE_UNIT;
	wire arb_loss = m_state == i2c_bus_pkg::M_BIT && at_sample &&
		m_bits < `ACK_BIT && m_sending && ~m_sda_low && ~sda_s;
	wire byte_end = m_state == i2c_bus_pkg::M_BIT && tick && ph_last &&
		m_bits == `ACK_BIT;
	wire adr_nack = byte_end && addr_phase && ~ack_seen;
	wire dat_nack = byte_end && ~addr_phase && ~m_dir && ~ack_seen;
	wire start_ok = wr_mctrl && cmd_run && cmd_start && master_en;

	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			pre <= '0;
			ph <= 4'h0;
		end
		else if (~m_run)
		begin
			pre <= '0;
			ph <= 4'h0;
		end
		else if (~stretch)
		begin
			pre <= tick ? '0 : pre + 1'b1;
			if (tick)
				ph <= ph_last ? 4'h0 : ph + 4'h1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Master: sequencer

	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			m_state <= i2c_bus_pkg::M_IDLE;
			m_shift <= 8'h00;
			m_bits <= 4'h0;
			m_sda_low <= 1'b0;
			addr_phase <= 1'b0;
			ack_seen <= 1'b0;
			m_rx_data <= 8'h00;
		end
		else
		begin
			case (m_state)
			i2c_bus_pkg::M_IDLE:
				if (start_ok && bus_idle)
				begin
					m_state <= i2c_bus_pkg::M_START;
					m_shift <= master_target_address_reg;
					addr_phase <= 1'b1;
				end
			i2c_bus_pkg::M_WAIT:
				if (wr_mctrl && master_en)
				begin
					m_bits <= 4'h0;
					if (cmd_run && cmd_start)
					begin
						m_state <= i2c_bus_pkg::M_RSTART;
						m_shift <= master_target_address_reg;
						addr_phase <= 1'b1;
					end
					else if (cmd_run)
					begin
						m_state <= i2c_bus_pkg::M_BIT;
						m_shift <= m_dir ? 8'hFF : m_tx_data;
					end
					else if (reg_wdata[`CMD_STOP])
						m_state <= i2c_bus_pkg::M_STOP;
				end
			i2c_bus_pkg::M_START:
				if (tick)
				begin
					if (ph == `START_FALL_UNIT)
						m_sda_low <= 1'b1;
					if (ph_last)
					begin
						m_state <= i2c_bus_pkg::M_BIT;
						m_bits <= 4'h0;
					end
				end
			i2c_bus_pkg::M_RSTART:
				if (tick)
				begin
					if (ph == `DATA_SET_UNIT)
						m_sda_low <= 1'b0;
					if (ph_last)
						m_state <= i2c_bus_pkg::M_START;
				end
			i2c_bus_pkg::M_STOP:
				if (tick)
				begin
					if (ph == `DATA_SET_UNIT)
						m_sda_low <= 1'b1;
					if (ph == `STOP_RELEASE_UNIT)
						m_sda_low <= 1'b0;
					if (ph_last)
						m_state <= i2c_bus_pkg::M_IDLE;
				end
			i2c_bus_pkg::M_BIT:
				if (arb_loss)
				begin
					m_state <= i2c_bus_pkg::M_IDLE;
					m_sda_low <= 1'b0;
				end
				else if (tick)
				begin
					if (ph == `DATA_SET_UNIT)
					begin
						if (m_bits < `ACK_BIT)
							m_sda_low <= m_sending & ~m_shift[7];
						else
							m_sda_low <= ~m_sending & cmd_ack;
					end
					if (ph == `SAMPLE_UNIT)
					begin
						if (m_bits < `ACK_BIT)
							m_shift <= {m_shift[6:0], sda_s};
						else
							ack_seen <= ~sda_s;
					end
					if (ph_last && m_bits < `ACK_BIT)
						m_bits <= m_bits + 4'h1;
					if (ph_last && m_bits == `ACK_BIT)
					begin
						m_bits <= 4'h0;
						if (adr_nack || dat_nack)
							m_state <= i2c_bus_pkg::M_STOP;
						else if (addr_phase)
						begin
							addr_phase <= 1'b0;
							m_shift <= m_dir ? 8'hFF : m_tx_data;
						end
						else
						begin
							if (m_dir)
								m_rx_data <= m_shift;
							m_state <= cmd_stop ? i2c_bus_pkg::M_STOP
								: i2c_bus_pkg::M_WAIT;
						end
					end
				end
			default:
				m_state <= i2c_bus_pkg::M_IDLE;
			endcase
		end
	end

	// error flags, set wins over clear
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			err_adr <= 1'b0;
			err_dat <= 1'b0;
			err_arb <= 1'b0;
		end
		else
		begin
			err_adr <= adr_nack | (err_adr & ~wr_mctrl);
			err_dat <= dat_nack | (err_dat & ~wr_mctrl);
			err_arb <= arb_loss | (start_ok & m_state == i2c_bus_pkg::M_IDLE
				& ~bus_idle) | (err_arb & ~wr_mctrl);
		end
	end

	wire m_error = err_adr | err_dat | err_arb;

	////////////////////////////////////////////////////////////////////////
	// Slave

	i2c_bus_pkg::slave_state_t s_state;
	logic [7:0] s_shift;
	logic [3:0] s_bits;
	logic s_sda_low, s_is_addr, s_rw;

	wire s_scl_low = s_state == i2c_bus_pkg::S_HOLD_RX ||
		s_state == i2c_bus_pkg::S_HOLD_TX;
	wire s_match = s_shift[7:1] == own_addr && slave_en;
	wire s_byte_done = scl_fall && s_bits == `ACK_BIT;
	wire s_rx_set = s_state == i2c_bus_pkg::S_HOLD_RX && ~rx_req &&
		~s_is_addr;
	wire s_tx_set = s_byte_done && s_is_addr && s_match && s_shift[0];
	wire s_txack_set = s_state == i2c_bus_pkg::S_TXACK && scl_rise && ~sda_s;

	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			s_state <= i2c_bus_pkg::S_IDLE;
			s_shift <= 8'h00;
			s_bits <= 4'h0;
			s_sda_low <= 1'b0;
			s_is_addr <= 1'b0;
			s_rw <= 1'b0;
			s_rx_data <= 8'h00;
		end
		else if (start_det)
		begin
			s_state <= i2c_bus_pkg::S_RX;
			s_bits <= 4'h0;
			s_is_addr <= 1'b1;
			s_sda_low <= 1'b0;
		end
		else if (stop_det)
		begin
			s_state <= i2c_bus_pkg::S_IDLE;
			s_sda_low <= 1'b0;
		end
		else
		begin
			case (s_state)
			i2c_bus_pkg::S_IDLE:
				s_sda_low <= 1'b0;
			i2c_bus_pkg::S_RX:
				if (scl_rise)
				begin
					s_shift <= {s_shift[6:0], sda_s};
					s_bits <= s_bits + 4'h1;
				end
				else if (s_byte_done)
				begin
					if (s_is_addr && ~s_match)
						s_state <= i2c_bus_pkg::S_IDLE;
					else if (s_is_addr)
					begin
						s_rw <= s_shift[0];
						s_sda_low <= 1'b1;
						s_state <= i2c_bus_pkg::S_ACK;
					end
					else
						s_state <= i2c_bus_pkg::S_HOLD_RX;
				end
			i2c_bus_pkg::S_HOLD_RX:
				if (~rx_req)
				begin
					s_rx_data <= s_shift;
					s_sda_low <= 1'b1;
					s_state <= i2c_bus_pkg::S_ACK;
				end
			i2c_bus_pkg::S_ACK:
				if (scl_fall)
				begin
					// accept with low ack, then release
					s_sda_low <= 1'b0;
					s_bits <= 4'h0;
					s_is_addr <= 1'b0;
					s_state <= s_rw ? i2c_bus_pkg::S_HOLD_TX
						: i2c_bus_pkg::S_RX;
				end
			i2c_bus_pkg::S_HOLD_TX:
				if (~tx_req)
				begin
					s_shift <= s_tx_data;
					s_sda_low <= ~s_tx_data[7];
					s_state <= i2c_bus_pkg::S_TX;
				end
			i2c_bus_pkg::S_TX:
				if (scl_rise)
					s_bits <= s_bits + 4'h1;
				else if (scl_fall && s_bits == `ACK_BIT)
				begin
					s_sda_low <= 1'b0;
					s_state <= i2c_bus_pkg::S_TXACK;
				end
				else if (scl_fall)
				begin
					s_shift <= {s_shift[6:0], 1'b0};
					s_sda_low <= ~s_shift[6];
				end
			i2c_bus_pkg::S_TXACK:
				if (scl_rise)
					s_state <= sda_s ? i2c_bus_pkg::S_IDLE
						: i2c_bus_pkg::S_ACK;
			default:
				s_state <= i2c_bus_pkg::S_IDLE;
			endcase
		end
	end

	// Software requests, hardware set wins
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			rx_req <= 1'b0;
			tx_req <= 1'b0;
			first_byte <= 1'b0;
		end
		else
		begin
			rx_req <= s_rx_set | (rx_req & ~rd_sdata);
			tx_req <= s_tx_set | s_txack_set | (tx_req & ~wr_sdata);
			first_byte <= (s_byte_done & s_is_addr & s_match) |
				(first_byte & ~s_rx_set & ~s_tx_set);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Pins and read port

	assign serial_data_pin_out = 1'b0;
	assign serial_clock_pin_out = 1'b0;
	assign serial_data_pin_oe_n = ~(m_sda_low | s_sda_low);
	assign serial_clock_pin_oe_n = ~(m_scl_low | s_scl_low);

	wire [6:0] m_status = {bus_busy, m_state == i2c_bus_pkg::M_IDLE,
		err_arb, err_dat, err_adr, m_error, m_run};
	wire [2:0] s_status = {first_byte, tx_req, rx_req};

	always_comb
	begin
		case (reg_addr)
		`REG_TARGET: rd_mux = {24'h000000, master_target_address_reg};
		`REG_MCTRL: rd_mux = {25'h0000000, m_status};
		`REG_MDATA: rd_mux = {24'h000000, m_rx_data};
		`REG_DIV: rd_mux = {{(32-DIV_WIDTH){1'b0}}, clock_divider_value};
		`REG_SADDR: rd_mux = {25'h0000000, own_addr};
		`REG_SSTAT: rd_mux = {29'h00000000, s_status};
		`REG_SDATA: rd_mux = {24'h000000, s_rx_data};
		`REG_CONFIG: rd_mux = {30'h00000000, cfg};
		default: rd_mux = 32'h00000000;
		endcase
	end

	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
			reg_rdata <= 32'h00000000;
		else
			reg_rdata <= reg_rd ? rd_mux : 32'h00000000;
	end

	////////////////////////////////////////////////////////////////////////
	// Assertions

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!arst_n);

	AST_BUSY_ON_START: assert property (start_det |=> bus_busy)
		else $error("bus not busy after start");
	AST_FREE_ON_STOP: assert property (stop_det |=> ##1 ~bus_busy)
		else $error("bus still busy after stop");
	AST_START_IDLE: assert property (
		m_state == i2c_bus_pkg::M_IDLE ##1 m_state == i2c_bus_pkg::M_START
		|-> $past(bus_idle))
		else $error("master started on busy bus");
	AST_ARB_RETIRE: assert property (arb_loss |=>
		m_state == i2c_bus_pkg::M_IDLE && ~m_sda_low && err_arb)
		else $error("master kept driving after lost arbitration");
	AST_SDA_STABLE: assert property (
		(m_state == i2c_bus_pkg::M_BIT && ph >= `LOW_UNITS) ##1
		(m_state == i2c_bus_pkg::M_BIT && ph >= `LOW_UNITS)
		|-> $stable(m_sda_low))
		else $error("master data moved while clock high");
	AST_STRETCH_HOLD: assert property (stretch |=> $stable(ph))
		else $error("phase advanced while clock held low");
	AST_NACK_STOP: assert property (adr_nack |=>
		m_state == i2c_bus_pkg::M_STOP && err_adr)
		else $error("no stop after address nack");
	AST_UNIT_LEN: assert property (
		tick |=> ~tick)
		else $error("phase unit shorter than two clocks");
	AST_SLAVE_RELEASE: assert property (
		s_state == i2c_bus_pkg::S_TXACK |-> ~s_sda_low)
		else $error("slave drove data during master ack");
	AST_PIN_OD: assert property (
		~serial_data_pin_oe_n |-> (m_sda_low || s_sda_low))
		else $error("data pin enabled without pull request");

	COV_ADDR_NACK: cover property (adr_nack);
	COV_ARB_LOSS: cover property (arb_loss);
	COV_RSTART: cover property (m_state == i2c_bus_pkg::M_RSTART);
	COV_SLAVE_TX: cover property (s_txack_set);

endmodule

// ===== hdl/i2c_bus_pkg.sv
package i2c_bus_pkg;

	typedef enum logic [2:0] {
		M_IDLE,
		M_START,
		M_BIT,
		M_WAIT,
		M_RSTART,
		M_STOP
	} master_state_t;

	typedef enum logic [2:0] {
		S_IDLE,
		S_RX,
		S_HOLD_RX,
		S_ACK,
		S_HOLD_TX,
		S_TX,
		S_TXACK
	} slave_state_t;

endpackage

// ===== verif/bus_slave_model.sv
module bus_slave_model #(
	parameter logic [6:0] ADDR = 7'h3B
) (
	input wire logic scl,
	input wire logic sda,
	input wire logic [7:0] tx_byte,
	input wire logic [15:0] stretch_ns,
	output logic [7:0] rx_byte,
	output logic sda_oe_n,
	output logic scl_oe_n
);
	timeunit 1ns;
	timeprecision 1ns;

	logic [7:0] head;

	////////////////////////////////////////////////////////////////
	// eight bits, first is MSB
	task automatic get_byte(output logic [7:0] b);
		repeat (8) @(posedge scl) b = {b[6:0], sda};
	endtask

	// pull data low for one clock
	task automatic ack();
		@(negedge scl);
		sda_oe_n = 1'b0;
		@(negedge scl);
		sda_oe_n = 1'b1;
	endtask

	// change in low phase, release for acknowledge
	task automatic send_byte(input logic [7:0] d);
		for (int i = 7; i >= 0; i--)
		begin
			sda_oe_n = d[i];
			@(negedge scl);
		end
		sda_oe_n = 1'b1;
		@(posedge scl);
	endtask

	////////////////////////////////////////////////////////////////
	initial
	begin
		sda_oe_n = 1'b1;
		scl_oe_n = 1'b1;
		rx_byte = 8'h00;
		forever
		begin
			@(negedge sda iff scl === 1'b1);
			get_byte(head);
			if (head[7:1] == ADDR)
			begin
				ack();
				if (stretch_ns != 16'h0)
				begin
					scl_oe_n = 1'b0;
					#(stretch_ns);
					scl_oe_n = 1'b1;
				end
				if (head[0])
					send_byte(tx_byte);
				else
				begin
					get_byte(rx_byte);
					ack();
				end
			end
		end
	end
endmodule

// ===== verif/test_i2c_master_slave_bus_engine.sv
module test_i2c_master_slave_bus_engine;
	timeunit 1ns;
	timeprecision 1ns;

	localparam logic [6:0] FAR_ADDR = 7'h3B;
	localparam logic [6:0] OWN_ADDR = 7'h2A;
	logic ref_clk = 1'b0;
	logic arst_n = 1'b0;
	logic [4:0] reg_addr = 5'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [31:0] reg_rdata;
	logic sda_oe_n, scl_oe_n, far_sda_oe_n, far_scl_oe_n;
	logic bb_sda_oe_n = 1'b1;
	logic bb_scl_oe_n = 1'b1;
	logic [7:0] far_tx = 8'h00;
	logic [7:0] far_rx;
	logic [15:0] stretch_ns = 16'h0;
	logic scl_q = 1'b1;
	int miscompares = 0;
	int comparisons = 0;
	int seed = 32'h3ADF0746;
	int cyc = 0, rises = 0, last_rise = 0, period = 0;
	wire sda = sda_oe_n & far_sda_oe_n & bb_sda_oe_n;
	wire scl = scl_oe_n & far_scl_oe_n & bb_scl_oe_n;

	i2c_bus_engine DUT (
		.ref_clk(ref_clk),
		.arst_n(arst_n),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_wr(reg_wr),
		.reg_rd(reg_rd),
		.reg_rdata(reg_rdata),
		.serial_data_pin_in(sda),
		.serial_data_pin_out(),
		.serial_data_pin_oe_n(sda_oe_n),
		.serial_clock_pin_in(scl),
		.serial_clock_pin_out(),
		.serial_clock_pin_oe_n(scl_oe_n)
	);

	bus_slave_model #(.ADDR(FAR_ADDR)) far_end (
		.scl(scl),
		.sda(sda),
		.tx_byte(far_tx),
		.stretch_ns(stretch_ns),
		.rx_byte(far_rx),
		.sda_oe_n(far_sda_oe_n),
		.scl_oe_n(far_scl_oe_n)
	);

	always #20 ref_clk = ~ref_clk;

	// Clock period seen on the wire
	always @(posedge ref_clk)
	begin
		cyc++;
		scl_q <= scl;
		if (scl && !scl_q)
		begin
			rises++;
			if (rises == 3)
				period = cyc - last_rise;
			last_rise = cyc;
		end
	end

	////////////////////////////////////////////////////////////////
	task automatic end_of_test();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic compare(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			miscompares++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic reg_write(input logic [4:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask

	task automatic reg_read(input logic [4:0] a, output logic [31:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask

	task automatic wait_master(input logic free);
		logic [31:0] st;
		int n;
		n = 0;
		do
		begin
			reg_read(5'h04, st);
			n++;
		end
		while ((st[0] !== 1'b0 || (free && st[6] !== 1'b0)) && n < 4000);
		if (n >= 4000)
		begin
			miscompares++;
			end_of_test();
		end
	endtask

	////////////////////////////////////////////////////////////////
	// Bench as outside master, 320 ns link clock
	task automatic bb_bit(input logic b, output logic r);
		int n;
		n = 0;
		@(posedge ref_clk);
		bb_sda_oe_n <= b;
		repeat (3) @(posedge ref_clk);
		bb_scl_oe_n <= 1'b1;
		do
		begin
			@(posedge ref_clk);
			n++;
		end
		while (scl !== 1'b1 && n < 1000);
		if (n >= 1000)
		begin
			miscompares++;
			end_of_test();
		end
		@(posedge ref_clk);
		r = sda;
		repeat (2) @(posedge ref_clk);
		bb_scl_oe_n <= 1'b0;
	endtask

	task automatic bb_byte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
			bb_bit(d[i], r);
		bb_bit(1'b1, ack);
	endtask

	task automatic bb_start();
		@(posedge ref_clk);
		bb_sda_oe_n <= 1'b0;
		repeat (4) @(posedge ref_clk);
		bb_scl_oe_n <= 1'b0;
	endtask

	task automatic bb_stop();
		@(posedge ref_clk);
		bb_sda_oe_n <= 1'b0;
		repeat (3) @(posedge ref_clk);
		bb_scl_oe_n <= 1'b1;
		repeat (4) @(posedge ref_clk);
		bb_sda_oe_n <= 1'b1;
		repeat (4) @(posedge ref_clk);
	endtask

	////////////////////////////////////////////////////////////////
	initial
	begin
		logic [31:0] st;
		logic [7:0] d;
		logic [7:0] div;
		logic [7:0] rd;
		logic ack;
		repeat (20) @(posedge ref_clk);
		arst_n <= 1'b1;
		repeat (4) @(posedge ref_clk);
		reg_read(5'h0C, st);
		compare(st, 32'h1);
		reg_read(5'h1C, st);
		compare(st, 32'h0);
		reg_read(5'h04, st);
		compare(st, 32'h20);
		$display("test reset done");
		reg_write(5'h1C, 32'h3);
		// Send then repeated start and receive
		repeat (3)
		begin
			div = 8'(1 + {$random(seed)} % 3);
			d = 8'($random(seed));
			far_tx <= 8'($random(seed));
			stretch_ns <= 16'h0;
			reg_write(5'h0C, {24'h0, div});
			reg_write(5'h00, {24'h0, FAR_ADDR, 1'b0});
			reg_write(5'h08, {24'h0, d});
			rises = 0;
			reg_write(5'h04, 32'h3);
			wait_master(1'b0);
			compare({24'h0, far_rx}, {24'h0, d});
			compare(32'(period), 32'(20 * (1 + div)));
			stretch_ns <= 16'h07D0;
			reg_write(5'h00, {24'h0, FAR_ADDR, 1'b1});
			reg_write(5'h04, 32'h7);
			wait_master(1'b1);
			reg_read(5'h08, st);
			compare({24'h0, st[7:0]}, {24'h0, far_tx});
			reg_read(5'h04, st);
			compare({31'h0, st[1]}, 32'h0);
			compare({30'h0, scl, sda}, 32'h3);
		end
		$display("test master transfer done");
		reg_write(5'h00, {24'h0, 7'h11, 1'b0});
		reg_write(5'h04, 32'h7);
		wait_master(1'b1);
		reg_read(5'h04, st);
		compare({30'h0, st[2:1]}, 32'h3);
		compare({30'h0, scl, sda}, 32'h3);
		$display("test address refused done");
		bb_start();
		reg_write(5'h04, 32'h7);
		reg_read(5'h04, st);
		compare({30'h0, st[4], st[1]}, 32'h3);
		compare({31'h0, sda_oe_n}, 32'h1);
		bb_stop();
		$display("test busy bus done");
		d = 8'($random(seed));
		reg_write(5'h10, {25'h0, OWN_ADDR});
		bb_start();
		bb_byte({7'h55, 1'b0}, ack);
		compare({31'h0, ack}, 32'h1);
		bb_stop();
		bb_start();
		bb_byte({OWN_ADDR, 1'b0}, ack);
		compare({31'h0, ack}, 32'h0);
		bb_byte(d, ack);
		compare({31'h0, ack}, 32'h0);
		bb_stop();
		reg_read(5'h14, st);
		compare({31'h0, st[0]}, 32'h1);
		reg_read(5'h18, st);
		compare({24'h0, st[7:0]}, {24'h0, d});
		compare({30'h0, scl, sda}, 32'h3);
		$display("test slave receive done");
		// Slave transmit, two bytes, last one declined
		bb_start();
		bb_byte({OWN_ADDR, 1'b1}, ack);
		compare({31'h0, ack}, 32'h0);
		for (int k = 0; k < 2; k++)
		begin
			reg_read(5'h14, st);
			compare({31'h0, st[1]}, 32'h1);
			d = 8'($random(seed));
			reg_write(5'h18, {24'h0, d});
			for (int i = 7; i >= 0; i--)
				bb_bit(1'b1, rd[i]);
			bb_bit(k[0], ack);
			compare({24'h0, rd}, {24'h0, d});
		end
		reg_read(5'h14, st);
		compare({31'h0, st[1]}, 32'h0);
		compare({31'h0, sda}, 32'h1);
		bb_stop();
		compare({30'h0, scl, sda}, 32'h3);
		$display("test slave transmit done");
		end_of_test();
	end
endmodule
